// ### logic/dec_pkg.sv
// dec_pkg: register map, field positions, reset values and carrier types
// for the dma channel event/interrupt control block.
// assumes an AXI4-Lite register bus with 32-bit data and 12-bit addresses.
package dec_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_EVENT = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_INT = 12'h008;

    typedef enum logic [1:0] {
        REG_CTRL = 2'b00,
        REG_EVENT = 2'b01,
        REG_INT = 2'b10,
        REG_NONE = 2'b11
    } dec_reg_t;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // channel_control fields
    // ------------------------------------------------------------
    localparam int CTRL_ACTIVE_BIT = 15;
    localparam int CTRL_DIR_BIT = 8;
    localparam int CTRL_ON_BIT = 7;
    localparam int CTRL_EVOFF_BIT = 6;
    localparam int CTRL_CHAIN_BIT = 5;
    localparam int CTRL_AUTO_BIT = 4;
    localparam int CTRL_SEEN_BIT = 2;
    localparam int CTRL_PRIO_LSB = 0;

    // ------------------------------------------------------------
    // channel_event_control fields
    // ------------------------------------------------------------
    localparam int EV_ASEL_LSB = 16;
    localparam int EV_SSEL_LSB = 8;
    localparam int EV_FORCE_BIT = 7;
    localparam int EV_ABORT_BIT = 6;
    localparam int EV_PATTERN_ABORT_ENABLE_BIT = 5;
    localparam int EV_SIE_BIT = 4;
    localparam int EV_AIE_BIT = 3;
    localparam logic [7:0] SEL_RESET = 8'hff;

    // ------------------------------------------------------------
    // channel_interrupt_control fields
    // ------------------------------------------------------------
    localparam int INT_IE_LSB = 16;
    localparam int INT_FLAG_LSB = 0;
    localparam int FL_SRC_DONE = 7;
    localparam int FL_SRC_HALF = 6;
    localparam int FL_DST_DONE = 5;
    localparam int FL_DST_HALF = 4;
    localparam int FL_BLOCK = 3;
    localparam int FL_CELL = 2;
    localparam int FL_ABORT = 1;
    localparam int FL_ADDR_ERR = 0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic active;
        logic cell_done;
        logic pattern_hit;
        logic addr_error;
        logic [16:0] src_ptr;
        logic [15:0] src_size;
        logic [16:0] dst_ptr;
        logic [15:0] dst_size;
    } dec_prog_t;

    typedef struct packed {
        logic start;
        logic abort;
        logic channel_on;
        logic chain_allow;
        logic chain_dir;
        logic [1:0] priority_lvl;
    } dec_cmd_t;

endpackage : dec_pkg

// ### logic/dec_channel_ctrl.sv
// dec_channel_ctrl: control, event and interrupt logic of one dma channel.
// assumes irq_pulse carries one-cycle synchronous interrupt pulses and that
// the transfer engine reports pointers, sizes and events in prog.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module dec_channel_ctrl
    import dec_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // system interrupt sources and transfer engine
    input wire logic [255:0] irq_pulse,
    input wire dec_prog_t prog,
    // commands to the transfer engine and interrupt out
    output var dec_cmd_t cmd,
    output logic irq
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic chan_on, evt_when_off, chain_allow, auto_reenable, event_seen, chain_dir;
    logic [1:0] channel_priority;
    logic [7:0] abort_irq_select, start_irq_select;
    logic pattern_abort_enable, start_irq_enable, abort_irq_enable;
    logic [7:0] ie, flag;
    logic pend_start;
    logic [4:0] cond_prev;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic dec_reg_t reg_index(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CTRL: reg_index = REG_CTRL;
            OFS_EVENT: reg_index = REG_EVENT;
            OFS_INT: reg_index = REG_INT;
            default: reg_index = REG_NONE;
        endcase
    endfunction : reg_index

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        merge = m;
    endfunction : merge

    // a programmed size of 0 means 65536 bytes
    function automatic logic [16:0] full_size(input logic [15:0] s);
        full_size = {s == 16'h0000, s};
    endfunction : full_size

    function automatic logic [31:0] read_word(input dec_reg_t idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            REG_CTRL: begin
                w[CTRL_ACTIVE_BIT] = prog.active;
                w[CTRL_DIR_BIT] = chain_dir;
                w[CTRL_ON_BIT] = chan_on;
                w[CTRL_EVOFF_BIT] = evt_when_off;
                w[CTRL_CHAIN_BIT] = chain_allow;
                w[CTRL_AUTO_BIT] = auto_reenable;
                w[CTRL_SEEN_BIT] = event_seen;
                w[CTRL_PRIO_LSB +: 2] = channel_priority;
            end
            REG_EVENT: begin
                w[EV_ASEL_LSB +: 8] = abort_irq_select;
                w[EV_SSEL_LSB +: 8] = start_irq_select;
                w[EV_PATTERN_ABORT_ENABLE_BIT] = pattern_abort_enable;
                w[EV_SIE_BIT] = start_irq_enable;
                w[EV_AIE_BIT] = abort_irq_enable;
            end
            REG_INT: begin
                w[INT_IE_LSB +: 8] = ie;
                w[INT_FLAG_LSB +: 8] = flag;
            end
            default: w = 32'h0000_0000;
        endcase
        read_word = w;
    endfunction : read_word

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    dec_reg_t wr_idx;
    logic [31:0] wr_word;
    logic wr_ctrl, wr_event, wr_int;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx = reg_index(aw_addr);
    assign wr_word = merge(read_word(wr_idx), w_data, w_strb);
    assign wr_ctrl = do_write && (wr_idx == REG_CTRL);
    assign wr_event = do_write && (wr_idx == REG_EVENT);
    assign wr_int = do_write && (wr_idx == REG_INT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (!aw_held) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (!w_held) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_idx == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    dec_reg_t ar_idx;
    logic ar_event;

    assign ar_idx = reg_index(s_axi_araddr);
    assign ar_event = s_axi_arvalid && s_axi_arready && (ar_idx == REG_EVENT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word(ar_idx);
            s_axi_rresp <= (ar_idx == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    logic gate, irq_start, irq_abort, sw_force, sw_abort, pat_abort;
    logic start_now, abort_now, blk_evt;
    logic [16:0] ssz, dsz;
    logic [4:0] cond, rise;
    logic [7:0] flag_set;

    assign gate = chan_on || evt_when_off;
    assign irq_start = start_irq_enable && irq_pulse[start_irq_select] && gate;
    assign irq_abort = abort_irq_enable && irq_pulse[abort_irq_select] && gate;
    assign sw_force = wr_event && w_strb[0] && w_data[EV_FORCE_BIT];
    assign sw_abort = wr_event && w_strb[0] && w_data[EV_ABORT_BIT];
    assign pat_abort = prog.pattern_hit && pattern_abort_enable;
    // a start seen while off is held and issued once the channel is on
    assign start_now = sw_force || (chan_on && (irq_start || pend_start));
    assign abort_now = sw_abort || irq_abort || pat_abort;

    assign ssz = full_size(prog.src_size);
    assign dsz = full_size(prog.dst_size);
    // idle pointers would match a tiny size; only a running channel counts
    assign cond[4] = prog.active && (prog.src_ptr == ssz);
    assign cond[3] = prog.active && (prog.src_ptr == {1'b0, ssz[16:1]});
    assign cond[2] = prog.active && (prog.dst_ptr == dsz);
    assign cond[1] = prog.active && (prog.dst_ptr == {1'b0, dsz[16:1]});
    assign cond[0] = (ssz >= dsz) ? cond[4] : cond[2];
    assign rise = cond & ~cond_prev;
    assign blk_evt = rise[0];

    assign flag_set = {rise[4:1], blk_evt || pat_abort, prog.cell_done,
                       irq_abort || sw_abort, prog.addr_error};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cond_prev <= 5'h00;
        end else begin
            cond_prev <= cond;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_start <= 1'b0;
        end else if (irq_start && !chan_on) begin
            pend_start <= 1'b1;
        end else if (start_now || abort_now) begin
            pend_start <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // channel_control
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_on <= 1'b0;
        end else if (wr_ctrl) begin
            chan_on <= wr_word[CTRL_ON_BIT];
        end else if (pat_abort || (blk_evt && !auto_reenable)) begin
            chan_on <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_when_off <= 1'b0;
            chain_allow <= 1'b0;
            auto_reenable <= 1'b0;
            chain_dir <= 1'b0;
            channel_priority <= 2'h0;
        end else if (wr_ctrl) begin
            evt_when_off <= wr_word[CTRL_EVOFF_BIT];
            chain_allow <= wr_word[CTRL_CHAIN_BIT];
            auto_reenable <= wr_word[CTRL_AUTO_BIT];
            chain_dir <= wr_word[CTRL_DIR_BIT];
            channel_priority <= wr_word[CTRL_PRIO_LSB +: 2];
        end
    end

    // detection wins over the end-of-block clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_seen <= 1'b0;
        end else if (irq_start || irq_abort) begin
            event_seen <= 1'b1;
        end else if (blk_evt || abort_now) begin
            event_seen <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // channel_event_control
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            abort_irq_select <= SEL_RESET;
            start_irq_select <= SEL_RESET;
            pattern_abort_enable <= 1'b0;
            start_irq_enable <= 1'b0;
            abort_irq_enable <= 1'b0;
        end else if (wr_event) begin
            abort_irq_select <= wr_word[EV_ASEL_LSB +: 8];
            start_irq_select <= wr_word[EV_SSEL_LSB +: 8];
            pattern_abort_enable <= wr_word[EV_PATTERN_ABORT_ENABLE_BIT];
            start_irq_enable <= wr_word[EV_SIE_BIT];
            abort_irq_enable <= wr_word[EV_AIE_BIT];
        end
    end

    // ------------------------------------------------------------
    // channel_interrupt_control
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie <= 8'h00;
        end else if (wr_int) begin
            ie <= wr_word[INT_IE_LSB +: 8];
        end
    end

    for (genvar gi = 0; gi < 8; gi++) begin : g_flag
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                flag[gi] <= 1'b0;
            end else if (flag_set[gi]) begin
                flag[gi] <= 1'b1;
            end else if (wr_int) begin
                flag[gi] <= flag[gi] & wr_word[INT_FLAG_LSB + gi];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= '0;
            irq <= 1'b0;
        end else begin
            cmd.start <= start_now;
            cmd.abort <= abort_now;
            cmd.channel_on <= chan_on;
            cmd.chain_allow <= chain_allow;
            cmd.chain_dir <= chain_allow && chain_dir;
            cmd.priority_lvl <= channel_priority;
            irq <= |(flag & ie);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_AUTO_OFF: assert property (blk_evt && !auto_reenable && !wr_ctrl |=> !chan_on)
        else $error("channel stayed on after block without auto re-enable");
    AST_AUTO_ON: assert property (blk_evt && auto_reenable && chan_on
        && !wr_ctrl && !pat_abort |=> chan_on)
        else $error("channel dropped despite auto re-enable");
    AST_SEEN: assert property (irq_start || irq_abort |=> event_seen)
        else $error("event_seen not set after event");
    AST_PRIO: assert property (wr_ctrl |=> ##1 cmd.priority_lvl == $past(wr_word[1:0], 2))
        else $error("priority output does not follow write");
    AST_CHAIN: assert property (!chain_allow |=> !cmd.chain_dir)
        else $error("chain direction active without chain_allow");
    AST_ABORT_IRQ: assert property (irq_abort |=> cmd.abort && flag[FL_ABORT])
        else $error("abort interrupt did not abort and flag");
    AST_ABORT_IGN: assert property (!abort_irq_enable && !sw_abort && !pat_abort |=> !cmd.abort)
        else $error("abort issued while abort sources are off");
    AST_START_IRQ: assert property (irq_start && chan_on |=> cmd.start)
        else $error("start interrupt did not start");
    AST_START_IGN: assert property (!start_irq_enable && !sw_force && !pend_start |=> !cmd.start)
        else $error("start issued while start interrupt disabled");
    AST_FORCE: assert property (sw_force |=> cmd.start)
        else $error("force write did not start a transfer");
    AST_SW_ABORT: assert property (sw_abort |=> cmd.abort && flag[FL_ABORT])
        else $error("abort write did not abort");
    AST_STROBE_RD: assert property ($past(ar_event) |-> s_axi_rdata[7:6] == 2'b00)
        else $error("strobe bits read back nonzero");
    AST_PATTERN: assert property (pat_abort && !wr_ctrl
        |=> !chan_on && cmd.abort && flag[FL_BLOCK])
        else $error("pattern hit did not abort");
    AST_SRC_DONE: assert property (rise[4] |=> flag[FL_SRC_DONE])
        else $error("source done flag missing");
    AST_FLAG_SET: assert property (flag_set != 8'h00
        |=> (flag & $past(flag_set)) == $past(flag_set))
        else $error("a flag event was lost");
    AST_STICKY: assert property (!wr_int |=> (flag & $past(flag)) == $past(flag))
        else $error("flag cleared without a write");
    AST_IRQ: assert property ((flag & ie) != 8'h00 |=> irq)
        else $error("irq does not follow enabled flags");
    AST_IRQ_OFF: assert property ((flag & ie) == 8'h00 |=> !irq)
        else $error("irq high with no enabled flag");

endmodule : dec_channel_ctrl

`default_nettype wire

// ### verif/dec_far_model.sv
// dec_far_model: interrupt sources and a toy transfer engine.
// assumes the channel's cmd outputs; fire and fault come from the bench.
`timescale 1ns/10ps
`default_nettype none
module dec_far_model
    import dec_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench requests and channel commands
    input wire logic [8:0] fire,
    input wire logic [1:0] fault,
    input var dec_cmd_t cmd,
    // toward the channel
    output logic [255:0] irq_pulse,
    output var dec_prog_t prog
);
    always_ff @(posedge aclk) begin
        irq_pulse <= fire[8] ? (256'h1 << fire[7:0]) : '0;
    end
    // one byte a cycle; source side is the smaller one and stops early
    always_ff @(posedge aclk) begin
        prog.src_size <= 16'h0008;
        prog.dst_size <= 16'h0010;
        prog.pattern_hit <= fault[0];
        prog.addr_error <= fault[1];
        prog.cell_done <= prog.active && prog.dst_ptr[1:0] == 2'h3;
        if (!aresetn || cmd.abort || (prog.active && prog.dst_ptr == 17'h00010)) begin
            prog.active <= 1'b0;
        end else if (cmd.start) begin
            prog.active <= 1'b1;
        end
        if (!aresetn || cmd.start) begin
            prog.src_ptr <= 17'h0;
            prog.dst_ptr <= 17'h0;
        end else if (prog.active && prog.dst_ptr != 17'h00010) begin
            prog.dst_ptr <= prog.dst_ptr + 17'h1;
            prog.src_ptr <= prog.src_ptr + {16'h0, prog.src_ptr != 17'h00008};
        end
    end
endmodule : dec_far_model
`default_nettype wire

// ### verif/tb.sv
// tb: register-level tests of the channel control block.
// assumes dec_far_model as the interrupt sources and transfer engine.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import dec_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, rdat;
    logic [1:0] bresp, rresp, rsp, bsp;
    logic [8:0] fire = 9'h0;
    logic [1:0] fault = 2'h0;
    dec_cmd_t cmd;
    dec_prog_t prog;
    logic [255:0] irq_pulse;
    int failures = 0, checked = 0;
    always #25 aclk = ~aclk;
    dec_channel_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .irq_pulse(irq_pulse), .prog(prog), .cmd(cmd), .irq(irq));
    dec_far_model far (.aclk(aclk), .aresetn(aresetn), .fire(fire), .fault(fault),
        .cmd(cmd), .irq_pulse(irq_pulse), .prog(prog));
    task automatic conclude;
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // bready and rready are tied high, so every answer is taken at once
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        if (bvalid !== 1'b1) failures++;
        bsp = bresp;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        if (rvalid !== 1'b1) failures++;
        rdat = rdata;
        rsp = rresp;
    endtask : rd
    task automatic rc(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
        rd(a);
        chk(rdat & m, e);
    endtask : rc
    // software side: after clearing channel_on, poll channel_active until idle
    task automatic idle;
        int n;
        n = 0;
        do begin
            rd(OFS_CTRL);
            n++;
        end while (rdat[CTRL_ACTIVE_BIT] !== 1'b0 && n < 40);
        chk(rdat & 32'h0000_8080, 32'h0);
    endtask : idle
    task automatic pulse(input logic [8:0] f, input logic [1:0] x);
        fire <= f;
        fault <= x;
        @(posedge aclk);
        fire <= 9'h0;
        fault <= 2'h0;
        @(posedge aclk);
    endtask : pulse
    // bounded wait for the engine to go idle, then let the flags land
    task automatic fin;
        int n;
        n = 0;
        repeat (3) @(posedge aclk);
        while (prog.active === 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        if (prog.active === 1'b1) failures++;
        repeat (2) @(posedge aclk);
    endtask : fin
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(OFS_CTRL, 32'h0);
        rc(OFS_EVENT, 32'h00ffff00);
        rc(OFS_INT, 32'h0);
        rc(12'h00c, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(12'h00c, 32'hffffffff);
        chk({30'h0, bsp}, {30'h0, RESP_SLVERR});
        wr(OFS_CTRL, 32'h00000183);
        repeat (2) @(posedge aclk);
        chk({29'h0, cmd.chain_dir, cmd.priority_lvl}, 32'h3);
        wr(OFS_CTRL, 32'h000001a1);
        repeat (2) @(posedge aclk);
        chk({29'h0, cmd.chain_dir, cmd.priority_lvl}, 32'h5);
        wr(OFS_CTRL, 32'h00000183);
        wr(OFS_INT, 32'h00ff0000);
        wr(OFS_EVENT, 32'h00090518);
        rc(OFS_EVENT, 32'h00090518);
        pulse(9'h105, 2'h0);
        // engine goes active one edge after cmd.start
        @(posedge aclk);
        rc(OFS_CTRL, 32'h00008004, 32'h00008004);
        fin();
        rc(OFS_INT, 32'h00ff00fc);
        chk({31'h0, irq}, 32'h1);
        rc(OFS_CTRL, 32'h0, 32'h80);
        wr(OFS_INT, 32'h000000fc);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rc(OFS_INT, 32'h000000fc);
        wr(OFS_INT, 32'h00ff0000);
        rc(OFS_INT, 32'h00ff0000);
        wr(OFS_CTRL, 32'h00000193);
        pulse(9'h105, 2'h0);
        fin();
        rc(OFS_CTRL, 32'h80, 32'h80);
        wr(OFS_INT, 32'h00ff0000);
        wr(OFS_EVENT, 32'h00090508);
        pulse(9'h105, 2'h0);
        fin();
        rc(OFS_INT, 32'h00ff0000);
        wr(OFS_EVENT, 32'h00090518);
        pulse(9'h105, 2'h0);
        pulse(9'h109, 2'h0);
        fin();
        rc(OFS_INT, 32'h2, 32'ha);
        wr(OFS_INT, 32'h00ff0000);
        wr(OFS_EVENT, 32'h00090510);
        pulse(9'h105, 2'h0);
        pulse(9'h109, 2'h0);
        fin();
        rc(OFS_INT, 32'h8, 32'ha);
        wr(OFS_INT, 32'h00ff0000);
        wr(OFS_EVENT, 32'h00090590);
        rc(OFS_CTRL, 32'h8000, 32'h8000);
        wr(OFS_CTRL, 32'h00000113);
        wr(OFS_EVENT, 32'h00090550);
        idle();
        fin();
        rc(OFS_EVENT, 32'h00090510);
        rc(OFS_INT, 32'h2, 32'ha);
        wr(OFS_INT, 32'h00ff0000);
        wr(OFS_CTRL, 32'h00000193);
        wr(OFS_EVENT, 32'h00090530);
        pulse(9'h105, 2'h0);
        pulse(9'h000, 2'h1);
        fin();
        rc(OFS_CTRL, 32'h0, 32'h80);
        rc(OFS_INT, 32'h8, 32'h8);
        pulse(9'h000, 2'h2);
        rc(OFS_INT, 32'h1, 32'h1);
        conclude();
    end
endmodule : tb
`default_nettype wire
